// File: rtl/cmpu_dec_if.sv
`timescale 1ns/1ps
// Decoded operation between decoder and datapath
interface cmpu_dec_if;
   cmpu_pkg::cmpu_op_e op;
   logic [4:0]         dest_index;
   logic [31:0]        operand_two;

   modport dec (output op, output dest_index, output operand_two);
   modport exe (input op, input dest_index, input operand_two);
endinterface

// File: rtl/cmpu_decoder.sv
`timescale 1ns/1ps
module cmpu_decoder (
   input  wire logic [31:0] i_instr,
   input  wire logic [31:0] i_source_two_reg,
   cmpu_dec_if.dec          dec
);
   logic [5:0] opcode;
   logic [5:0] opx;
   logic [4:0] shamt;
   logic [15:0] immediate_sixteen;

   // Field extraction
   // Opcode, extended opcode, shift and immediate fields
   assign opcode            = i_instr[cmpu_pkg::OP_MSB:cmpu_pkg::OP_LSB];
   assign opx               = i_instr[cmpu_pkg::OPX_MSB:cmpu_pkg::OPX_LSB];
   assign shamt             = i_instr[cmpu_pkg::SHAMT_MSB:cmpu_pkg::SHAMT_LSB];
   assign immediate_sixteen = i_instr[cmpu_pkg::IMM_MSB:cmpu_pkg::IMM_LSB];

   // Opcode decode; unmatched words yield no operation
   always_comb begin
      dec.op          = cmpu_pkg::CMPU_NONE;
      dec.dest_index  = i_instr[cmpu_pkg::C_MSB:cmpu_pkg::C_LSB];
      dec.operand_two = i_source_two_reg;
      if (opcode == cmpu_pkg::OP_RTYPE && opx == cmpu_pkg::OPX_LTU) begin
         dec.op = cmpu_pkg::CMPU_LTU;
      end else if (opcode == cmpu_pkg::OP_RTYPE && opx == cmpu_pkg::OPX_NE &&
                   shamt == cmpu_pkg::SHAMT_ZERO) begin
         dec.op = cmpu_pkg::CMPU_NE;
      end else if (opcode == cmpu_pkg::OP_LTU_IMM) begin
         dec.op          = cmpu_pkg::CMPU_LTUI;
         dec.dest_index  = i_instr[cmpu_pkg::B_MSB:cmpu_pkg::B_LSB];
         dec.operand_two = {16'h0000, immediate_sixteen};
      end
   end
endmodule

// File: rtl/cmpu_pkg.sv
package cmpu_pkg;
   // Instruction word field positions
   localparam int A_MSB      = 31;
   localparam int A_LSB      = 27;
   localparam int B_MSB      = 26;
   localparam int B_LSB      = 22;
   localparam int C_MSB      = 21;
   localparam int C_LSB      = 17;
   localparam int OPX_MSB    = 16;
   localparam int OPX_LSB    = 11;
   localparam int SHAMT_MSB  = 10;
   localparam int SHAMT_LSB  = 6;
   localparam int IMM_MSB    = 21;
   localparam int IMM_LSB    = 6;
   localparam int OP_MSB     = 5;
   localparam int OP_LSB     = 0;
   // Encodings
   localparam logic [5:0] OP_RTYPE    = 6'h3A;
   localparam logic [5:0] OP_LTU_IMM  = 6'h30;
   localparam logic [5:0] OPX_LTU     = 6'h30;
   localparam logic [5:0] OPX_NE      = 6'h18;
   localparam logic [4:0] SHAMT_ZERO  = 5'h00;
   // Reset values
   localparam logic [31:0] RESULT_RST = 32'h00000000;
   localparam logic [4:0]  INDEX_RST  = 5'h00;

   typedef enum {CMPU_NONE, CMPU_LTU, CMPU_LTUI, CMPU_NE} cmpu_op_e;
endpackage

// File: rtl/cmpu_unit.sv
`timescale 1ns/1ps
// Contract
// - Register unsigned less-than writes one or zero
// - Decode primary 0x3a, extended 0x30
// - Fields: source one at top, two, dest
// - Zero-extended immediate compared unsigned
// - Immediate form decoded by primary 0x30
// - Immediate unsigned; second field is destination
// - Inequality writes one when any bit differs
// - Decode 0x3a, 0x18, small field zero
module cmpu_unit (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_valid,
   input  wire logic [31:0] i_instr,
   input  wire logic [31:0] i_source_one_reg,
   input  wire logic [31:0] i_source_two_reg,
   output logic             o_wr_en,
   output logic [4:0]       o_dest_reg,
   output logic [31:0]      o_result,
   output logic             o_exception
);
   cmpu_dec_if dec_bus ();

   logic        wr_en;
   logic [4:0]  dest_reg;
   logic [31:0] result;
   logic        next_wr_en;
   logic [4:0]  next_dest_reg;
   logic [31:0] next_result;
   logic        cmp_bit;
   logic        exception;
   logic        next_exception;

   cmpu_decoder u_dec (
      .i_instr          (i_instr),
      .i_source_two_reg (i_source_two_reg),
      .dec              (dec_bus)
   );

   // Compare selection; single adder-free compare keeps the path short
   always_comb begin
      cmp_bit = 1'b0;
      case (dec_bus.op)
         cmpu_pkg::CMPU_LTU,
         cmpu_pkg::CMPU_LTUI: cmp_bit = (i_source_one_reg < dec_bus.operand_two);
         cmpu_pkg::CMPU_NE:   cmp_bit = (i_source_one_reg != dec_bus.operand_two);
         default:             cmp_bit = 1'b0;
      endcase
   end

   // Next write-back values; only recognised compares write
   always_comb begin
      next_wr_en    = 1'b0;
      next_dest_reg = dest_reg;
      next_result   = result;
      next_exception = 1'b0;
      if (i_valid && dec_bus.op != cmpu_pkg::CMPU_NONE) begin
         next_wr_en    = 1'b1;
         next_dest_reg = dec_bus.dest_index;
         next_result   = {31'h0, cmp_bit};
      end
   end

   // Write-back registers
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         wr_en    <= 1'b0;
         dest_reg <= cmpu_pkg::INDEX_RST;
         result   <= cmpu_pkg::RESULT_RST;
         exception <= 1'b0;
      end else begin
         wr_en    <= next_wr_en;
         dest_reg <= next_dest_reg;
         result   <= next_result;
         exception <= next_exception;
      end
   end

   assign o_wr_en    = wr_en;
   assign o_dest_reg = dest_reg;
   assign o_result   = result;
   assign o_exception = exception;

   // Shadow decode for the checks below, written apart from the decoder so that
   // a slip in one is not quietly copied into the other
   logic chk_ltu;
   logic chk_ltui;
   logic chk_ne;
   logic chk_rform;

   assign chk_rform = (i_instr[cmpu_pkg::OP_MSB:cmpu_pkg::OP_LSB] == cmpu_pkg::OP_RTYPE);
   assign chk_ltu   = chk_rform &&
                      (i_instr[cmpu_pkg::OPX_MSB:cmpu_pkg::OPX_LSB] == cmpu_pkg::OPX_LTU);
   assign chk_ltui  = (i_instr[cmpu_pkg::OP_MSB:cmpu_pkg::OP_LSB] == cmpu_pkg::OP_LTU_IMM);
   assign chk_ne    = chk_rform &&
                      (i_instr[cmpu_pkg::OPX_MSB:cmpu_pkg::OPX_LSB] == cmpu_pkg::OPX_NE) &&
                      (i_instr[cmpu_pkg::SHAMT_MSB:cmpu_pkg::SHAMT_LSB] == cmpu_pkg::SHAMT_ZERO);

   // Register compare answers one cycle after the word is taken
   property p_ltu;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_instr[5:0] == 6'h3A && i_instr[16:11] == 6'h30) |=>
      (o_wr_en && o_result == {31'h0, $past(i_source_one_reg) < $past(i_source_two_reg)});
   endproperty
   a_ltu: assert property (p_ltu) else $error("ltu result wrong");

   // Register compare writes to the third field
   property p_ltu_dest;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_instr[5:0] == 6'h3A && i_instr[16:11] == 6'h30) |=>
      o_dest_reg == $past(i_instr[21:17]);
   endproperty
   a_ltu_dest: assert property (p_ltu_dest) else $error("ltu dest wrong");

   // Immediate compare against the zero-padded field
   property p_ltui;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_instr[5:0] == 6'h30) |=>
      (o_wr_en && o_result[0] == ($past(i_source_one_reg) < {16'h0, $past(i_instr[21:6])}));
   endproperty
   a_ltui: assert property (p_ltui) else $error("ltui result wrong");

   // Immediate form writes to the second field
   property p_ltui_dest;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_instr[5:0] == 6'h30) |=> o_dest_reg == $past(i_instr[26:22]);
   endproperty
   a_ltui_dest: assert property (p_ltui_dest) else $error("ltui dest wrong");

   // A source above sixteen bits can never be below the immediate
   property p_ltui_big;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_instr[5:0] == 6'h30 && i_source_one_reg[31:16] != 16'h0) |=>
      o_result == 32'h0;
   endproperty
   a_ltui_big: assert property (p_ltui_big) else $error("ltui not unsigned");

   // Inequality result follows the sampled sources
   property p_ne;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_instr[5:0] == 6'h3A && i_instr[16:11] == 6'h18 && i_instr[10:6] == 5'h0)
      |=> (o_wr_en && o_result[0] == ($past(i_source_one_reg) != $past(i_source_two_reg)));
   endproperty
   a_ne: assert property (p_ne) else $error("ne result wrong");

   // A nonzero small field turns the inequality word away
   property p_ne_field;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_instr[5:0] == 6'h3A && i_instr[16:11] == 6'h18 && i_instr[10:6] != 5'h0)
      |=> !o_wr_en;
   endproperty
   a_ne_field: assert property (p_ne_field) else $error("ne decoded bad word");

   // Written results carry only the low bit
   property p_zext;
      @(posedge i_clk_sys) disable iff (i_reset)
      o_wr_en |-> (o_result[31:1] == 31'h0 && !o_exception);
   endproperty
   a_zext: assert property (p_zext) else $error("result not zero-extended");

   // Other register-format words leave write-back alone
   property p_other;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_instr[5:0] == 6'h3A && i_instr[16:11] != 6'h30 && i_instr[16:11] != 6'h18)
      |=> !o_wr_en;
   endproperty
   a_other: assert property (p_other) else $error("foreign word written");

   // Reset clears the whole write-back port on the following edge
   property p_rst;
      @(posedge i_clk_sys)
      i_reset |=> (!o_wr_en && o_dest_reg == cmpu_pkg::INDEX_RST &&
                   o_result == cmpu_pkg::RESULT_RST && !o_exception);
   endproperty
   a_rst: assert property (p_rst) else $error("reset left outputs set");

   // Idle cycles write nothing and leave the last result on the port
   property p_idle_hold;
      @(posedge i_clk_sys) disable iff (i_reset)
      !i_valid |=> (!o_wr_en && $stable(o_result) && $stable(o_dest_reg));
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle cycle moved outputs");

   // A differing top bit alone decides the order; a signed compare fails here
   property p_ltu_msb;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && chk_ltu && i_source_one_reg[31] != i_source_two_reg[31]) |=>
      (o_wr_en && o_result[0] == $past(i_source_two_reg[31]));
   endproperty
   a_ltu_msb: assert property (p_ltu_msb) else $error("ltu treated operands signed");

   // Differing upper halves settle the order before the lower halves count
   property p_ltu_upper;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && chk_ltu && i_source_one_reg[31:16] != i_source_two_reg[31:16]) |=>
      (o_result[0] == ($past(i_source_one_reg[31:16]) < $past(i_source_two_reg[31:16])));
   endproperty
   a_ltu_upper: assert property (p_ltu_upper) else $error("ltu upper order wrong");

   // Small first source below the immediate must give one
   property p_ltui_small;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && chk_ltui && i_source_one_reg[31:16] == 16'h0000 &&
       i_source_one_reg[15:0] < i_instr[cmpu_pkg::IMM_MSB:cmpu_pkg::IMM_LSB]) |=>
      (o_wr_en && o_result == 32'h00000001);
   endproperty
   a_ltui_small: assert property (p_ltui_small) else $error("ltui missed small source");

   // Inequality writes to the third field, like the other register form
   property p_ne_dest;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && chk_ne) |=>
      (o_wr_en && o_dest_reg == $past(i_instr[cmpu_pkg::C_MSB:cmpu_pkg::C_LSB]));
   endproperty
   a_ne_dest: assert property (p_ne_dest) else $error("ne dest wrong");

   // A difference in the upper half alone must already give one
   property p_ne_upper;
      @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && chk_ne && i_source_one_reg[31:16] != i_source_two_reg[31:16]) |=>
      (o_wr_en && o_result == 32'h00000001);
   endproperty
   a_ne_upper: assert property (p_ne_upper) else $error("ne missed upper difference");
endmodule

// File: tb/cmpu_regfile_model.sv
`timescale 1ns/1ps
// Register file and fetch side that faces the compare unit
module cmpu_regfile_model (
   input  wire logic        i_clk_sys,
   input  wire logic [31:0] i_instr,
   input  wire logic        i_wr_en,
   input  wire logic [4:0]  i_dest_reg,
   input  wire logic [31:0] i_result,
   output logic [31:0]      o_source_one_reg,
   output logic [31:0]      o_source_two_reg
);
   logic [31:0] regs [32];
   // Reads follow the index fields of the word being presented
   assign o_source_one_reg = regs[i_instr[31:27]];
   assign o_source_two_reg = regs[i_instr[26:22]];
   // Write-back lands after the read edge, so back-to-back words see old values
   always @(posedge i_clk_sys) begin
      if (i_wr_en === 1'b1) begin
         regs[i_dest_reg] <= i_result;
      end
   end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        i_clk_sys = 1'b0;
   logic        i_reset   = 1'b1;
   logic        i_valid   = 1'b0;
   logic [31:0] i_instr   = 32'h00000000;
   logic [31:0] src_one, src_two, o_result, a, b, w;
   logic        o_wr_en, o_exception;
   logic [4:0]  o_dest_reg;
   logic [37:0] exp_q [$];
   int          n_fail = 0;
   int          total_checks = 0;
   int          seed = 32'h0b4be696;

   always #5 i_clk_sys = ~i_clk_sys;

   cmpu_unit dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_valid(i_valid),
      .i_instr(i_instr), .i_source_one_reg(src_one), .i_source_two_reg(src_two),
      .o_wr_en(o_wr_en), .o_dest_reg(o_dest_reg), .o_result(o_result),
      .o_exception(o_exception));
   cmpu_regfile_model pm (.i_clk_sys(i_clk_sys), .i_instr(i_instr), .i_wr_en(o_wr_en),
      .i_dest_reg(o_dest_reg), .i_result(o_result), .o_source_one_reg(src_one),
      .o_source_two_reg(src_two));

   task automatic check(input logic [37:0] got, input logic [37:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Present one word; a taken compare notes {no exception, dest, zero-extended bit}
   task automatic issue(input logic [31:0] wd, input logic [31:0] va, input logic [31:0] vb,
                        input logic vld);
      logic [31:0] vbe;
      @(negedge i_clk_sys);
      pm.regs[wd[26:22]] = vb;
      pm.regs[wd[31:27]] = va;
      vbe = (wd[31:27] == wd[26:22]) ? va : vb;
      i_instr = wd;
      i_valid = vld;
      if (vld && wd[5:0] == 6'h30)
         exp_q.push_back({1'b0, wd[26:22], 31'h0, va < {16'h0000, wd[21:6]}});
      else if (vld && wd[5:0] == 6'h3A && wd[16:11] == 6'h30)
         exp_q.push_back({1'b0, wd[21:17], 31'h0, va < vbe});
      else if (vld && wd[5:0] == 6'h3A && wd[16:6] == {6'h18, 5'h00})
         exp_q.push_back({1'b0, wd[21:17], 31'h0, va != vbe});
   endtask

   // Every write-back is matched against the oldest note
   always @(negedge i_clk_sys) begin
      if (o_wr_en === 1'b1) begin
         if (exp_q.size() == 0) check(38'h1, 38'h0);
         else check({o_exception, o_dest_reg, o_result}, exp_q.pop_front());
      end
   end

   // Back-to-back mix of taken and refused words, boundary operand pairs
   initial begin
      repeat (3) @(negedge i_clk_sys);
      i_reset = 1'b0;
      for (int i = 0; i < 120; i++) begin
         w = $random(seed);
         a = $random(seed);
         if (i % 6 == 1 && i % 5 != 0) a[31:16] = 16'h0000;
         b = ((i / 6) % 3 == 0) ? a : ((i / 6) % 3 == 1) ? a + 32'h1 : $random(seed);
         case (i % 6)
            0: w = {w[31:17], 6'h30, w[10:6], 6'h3A};
            1: w = {w[31:22], b[15:0], 6'h30};
            2: w = {w[31:17], 6'h18, 5'h00, 6'h3A};
            3: w = {w[31:17], 6'h18, w[10:7], 1'b1, 6'h3A};
            default: w = {w[31:17], 6'h10, w[10:6], 6'h3A};
         endcase
         issue(w, a, b, i % 12 != 6);
      end
      $display("Compare sweep done");
      // Reset in mid-run clears the write-back outputs
      @(negedge i_clk_sys);
      i_valid = 1'b0;
      i_reset = 1'b1;
      @(negedge i_clk_sys);
      check({o_wr_en, o_dest_reg, o_result}, 38'h0);
      check({37'h0, exp_q.size() != 0}, 38'h0);
      i_reset = 1'b0;
      issue({5'h03, 5'h04, 5'h1F, 6'h30, 5'h00, 6'h3A}, 32'hFFFFFFFE, 32'hFFFFFFFF, 1'b1);
      @(negedge i_clk_sys);
      i_valid = 1'b0;
      repeat (2) @(negedge i_clk_sys);
      check({37'h0, exp_q.size() != 0}, 38'h0);
      $display("Reset test done");
      print_verdict();
   end

   // Cut a hang short well past the expected run length
   initial begin
      #20000;
      n_fail++;
      print_verdict();
   end
endmodule
